/* File: rtl/rmcd_decoder.sv */
/*
  Command decoder: strobe handshake, mode control, measurement command fields,
  acknowledge and result code of the module status word.
  Assumes the command word image and all status inputs are on this clock.
*/
`timescale 1ns/100ps
module rmcd_decoder
  import rmcd_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire rmcd_pkg::rmcd_word_t cmd_word,
  input wire logic config_valid,
  input wire logic setup_valid,
  input wire logic align_valid,
  input wire logic foreign_dual,
  input wire logic dual_multiturn,
  input wire logic align_enter,
  input wire logic [rmcd_pkg::POS1_W-1:0] pos1_value,
  input wire logic [rmcd_pkg::VAL_W-1:0] vel1_value,
  input wire logic [rmcd_pkg::VAL_W-1:0] pos2_value,
  input wire logic [rmcd_pkg::VAL_W-1:0] vel2_value,
  input wire logic led1_module_mode,
  input wire logic led1_module_val,
  input wire logic led1_chan_val,
  input wire logic led2_module_mode,
  input wire logic led2_module_val,
  input wire logic led2_chan_val,
  output logic ack_q,
  output rmcd_pkg::rmcd_result_t result_q,
  output logic in_meas_q,
  output logic initialized_q,
  output logic in_align_q,
  output logic fault_clear_q,
  output logic preset1_q,
  output logic preset2_q,
  output logic preset_flash_q,
  output logic coarse_discard_q,
  output logic coarse_save_q,
  output logic data_en1_q,
  output logic data_en2_q,
  output logic led_off1_q,
  output logic led_off2_q,
  output logic led1_q,
  output logic led2_q,
  output logic [rmcd_pkg::POS1_W-1:0] pos1_q,
  output logic [rmcd_pkg::VAL_W-1:0] vel1_q,
  output logic [rmcd_pkg::VAL_W-1:0] pos2_q,
  output logic [rmcd_pkg::VAL_W-1:0] vel2_q
);

  rmcd_state_t state_q;
  rmcd_state_t state_d;
  logic strobe_q;
  logic strobe_rise;
  logic meas_avail;
  logic is_meas_cmd;
  logic in_mt_range;
  logic mt_err;
  logic cmd_ok;
  logic apply_meas;
  logic do_exit;
  logic do_save;
  logic enter_meas;

  // Previous strobe level; the rising edge alone starts a command
  always_ff @(posedge clock) begin
    if (reset) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= cmd_word[BIT_STROBE];
    end
  end

  assign strobe_rise = cmd_word[BIT_STROBE] & ~strobe_q;

  assign meas_avail = config_valid & setup_valid & (~foreign_dual | align_valid);

  assign is_meas_cmd = (cmd_word[15:8] == MEAS_UPPER);
  assign in_mt_range = (cmd_word >= MT_ERR_LO) && (cmd_word <= MT_ERR_HI);

  // Channel 2 has no meaning once both resolvers form one multi-turn value
  assign mt_err = dual_multiturn & (cmd_word[BIT_PRESET2] | cmd_word[BIT_EN2]
    | (in_mt_range & (cmd_word[1:0] == MT_ERR_LOW_BITS)));

  always_comb begin
    cmd_ok = 1'b0;
    do_exit = 1'b0;
    do_save = 1'b0;
    unique case (state_q)
      ST_MEAS: begin
        cmd_ok = is_meas_cmd & ~mt_err;
      end
      ST_ALIGN: begin
        do_exit = (cmd_word == EXIT_CMD);
        do_save = (cmd_word == SAVE_EXIT_CMD);
        cmd_ok = do_exit | do_save;
      end
      ST_INIT: begin
        cmd_ok = 1'b0;
      end
    endcase
  end

  assign apply_meas = strobe_rise & cmd_ok & (state_q == ST_MEAS);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_INIT: begin
        if (meas_avail) begin
          state_d = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (align_enter) begin
          state_d = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (strobe_rise && do_save) begin
          state_d = (config_valid & setup_valid) ? ST_MEAS : ST_INIT;
        end else if (strobe_rise && do_exit) begin
          // An abandoned first alignment has nothing valid to measure with
          if (foreign_dual && !align_valid) begin
            state_d = ST_ALIGN;
          end else if (meas_avail) begin
            state_d = ST_MEAS;
          end else begin
            state_d = ST_INIT;
          end
        end
      end
    endcase
  end

  assign enter_meas = (state_d == ST_MEAS) && (state_q != ST_MEAS);

  // Reset lands in the init state with no save pulse, so held edits are gone
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      in_meas_q <= 1'b0;
      in_align_q <= 1'b0;
      initialized_q <= 1'b0;
    end else begin
      in_meas_q <= (state_d == ST_MEAS);
      in_align_q <= (state_d == ST_ALIGN);
      initialized_q <= config_valid & setup_valid;
    end
  end

  // Acknowledge handshake; a rise and a low strobe never share a cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= 1'b0;
      result_q <= RES_OK;
    end else if (strobe_rise) begin
      ack_q <= 1'b1;
      result_q <= cmd_ok ? RES_OK : RES_CMD_ERR;
    end else if (!cmd_word[BIT_STROBE]) begin
      ack_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      coarse_discard_q <= 1'b0;
      coarse_save_q <= 1'b0;
    end else begin
      coarse_discard_q <= strobe_rise & do_exit;
      coarse_save_q <= strobe_rise & do_save;
    end
  end

  // One-cycle action pulses of a measurement command
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_clear_q <= 1'b0;
      preset1_q <= 1'b0;
      preset2_q <= 1'b0;
      preset_flash_q <= 1'b0;
    end else begin
      fault_clear_q <= enter_meas | (apply_meas & cmd_word[BIT_CLR_FAULT]);
      preset1_q <= apply_meas & cmd_word[BIT_PRESET1];
      preset2_q <= apply_meas & cmd_word[BIT_PRESET2];
      preset_flash_q <= apply_meas & cmd_word[BIT_FLASH]
        & (cmd_word[BIT_PRESET1] | cmd_word[BIT_PRESET2]);
    end
  end

  // Every field is rewritten by each accepted measurement command, zeros included
  always_ff @(posedge clock) begin
    if (reset) begin
      data_en1_q <= RST_DATA_EN;
      data_en2_q <= RST_DATA_EN;
      led_off1_q <= RST_LED_OFF;
      led_off2_q <= RST_LED_OFF;
    end else if (apply_meas) begin
      data_en1_q <= cmd_word[BIT_EN1];
      data_en2_q <= cmd_word[BIT_EN2];
      led_off1_q <= cmd_word[BIT_LED_OFF1];
      led_off2_q <= cmd_word[BIT_LED_OFF2];
    end
  end

  // Module status display always overrides channel suppression
  always_ff @(posedge clock) begin
    if (reset) begin
      led1_q <= 1'b0;
      led2_q <= 1'b0;
    end else begin
      led1_q <= led1_module_mode ? led1_module_val : (led1_chan_val & ~led_off1_q);
      led2_q <= led2_module_mode ? led2_module_val : (led2_chan_val & ~led_off2_q);
    end
  end

  rmcd_gate #(.WIDTH(POS1_W)) u_pos1 (
    .clock(clock),
    .reset(reset),
    .enable(data_en1_q),
    .value(pos1_value),
    .gated_q(pos1_q)
  );

  rmcd_gate #(.WIDTH(VAL_W)) u_vel1 (
    .clock(clock),
    .reset(reset),
    .enable(data_en1_q),
    .value(vel1_value),
    .gated_q(vel1_q)
  );

  rmcd_gate #(.WIDTH(VAL_W)) u_pos2 (
    .clock(clock),
    .reset(reset),
    .enable(data_en2_q),
    .value(pos2_value),
    .gated_q(pos2_q)
  );

  rmcd_gate #(.WIDTH(VAL_W)) u_vel2 (
    .clock(clock),
    .reset(reset),
    .enable(data_en2_q),
    .value(vel2_value),
    .gated_q(vel2_q)
  );

  ack_rise_a: assert property (
    @(posedge clock) disable iff (reset)
    strobe_rise |=> ack_q
  ) else $error("ack not set after strobe edge");

  ack_release_a: assert property (
    @(posedge clock) disable iff (reset)
    !cmd_word[BIT_STROBE] |=> !ack_q
  ) else $error("ack not cleared after strobe low");

  held_strobe_a: assert property (
    @(posedge clock) disable iff (reset)
    (cmd_word[BIT_STROBE] && $past(cmd_word[BIT_STROBE]) && !enter_meas)
      |=> !preset1_q && !preset2_q && !fault_clear_q
  ) else $error("command re-executed with strobe held");

  exit_align_a: assert property (
    @(posedge clock) disable iff (reset)
    (state_q == ST_ALIGN && strobe_rise && cmd_word == EXIT_CMD && align_valid)
      |=> coarse_discard_q && !coarse_save_q && ack_q && !in_align_q
  ) else $error("exit command did not leave alignment");

  exit_realign_a: assert property (
    @(posedge clock) disable iff (reset)
    (state_q == ST_ALIGN && strobe_rise && cmd_word == EXIT_CMD
      && foreign_dual && !align_valid) |=> in_align_q && !in_meas_q
  ) else $error("exit without alignment data left alignment");

  meas_entry_a: assert property (
    @(posedge clock) disable iff (reset)
    $rose(in_meas_q) |-> fault_clear_q
  ) else $error("entry to measurement without fault clear");

  powerup_meas_a: assert property (
    @(posedge clock) disable iff (reset)
    (state_q == ST_INIT && meas_avail && config_valid) |=> in_meas_q && initialized_q
  ) else $error("available measurement not reported");

  meas_gate_a: assert property (
    @(posedge clock) disable iff (reset)
    (state_q == ST_INIT && !meas_avail) |=> !in_meas_q
  ) else $error("measurement entered without valid data");

  flash_store_a: assert property (
    @(posedge clock) disable iff (reset)
    preset_flash_q |-> (preset1_q || preset2_q)
  ) else $error("flash store without preset");

  mt_reject_a: assert property (
    @(posedge clock) disable iff (reset)
    (strobe_rise && state_q == ST_MEAS && dual_multiturn
      && (cmd_word[BIT_PRESET2] || cmd_word[BIT_EN2]))
      |=> result_q == RES_CMD_ERR && !preset2_q && !data_en2_q == !$past(data_en2_q)
  ) else $error("multi-turn channel 2 command not rejected");

  all_fields_a: assert property (
    @(posedge clock) disable iff (reset)
    apply_meas |=> data_en1_q == $past(cmd_word[BIT_EN1])
      && data_en2_q == $past(cmd_word[BIT_EN2])
      && led_off1_q == $past(cmd_word[BIT_LED_OFF1])
      && led_off2_q == $past(cmd_word[BIT_LED_OFF2])
  ) else $error("command fields not applied together");

  ch2_zero_a: assert property (
    @(posedge clock) disable iff (reset)
    !data_en2_q |=> pos2_q == '0 && vel2_q == '0
  ) else $error("disabled channel 2 data not zero");

  led_module_a: assert property (
    @(posedge clock) disable iff (reset)
    led1_module_mode |=> led1_q == $past(led1_module_val)
  ) else $error("channel 1 suppression hid module status");

  fault_bit_a: assert property (
    @(posedge clock) disable iff (reset)
    (apply_meas && cmd_word[BIT_CLR_FAULT]) |=> fault_clear_q
  ) else $error("fault clear bit ignored");

endmodule

/* File: rtl/rmcd_pkg.sv */
/*
  Constants, field positions and the mode type of the resolver command decoder.
  Assumes one 100 MHz clock domain shared with the network image logic.
*/
// How it works
// - Exit command drops edits, acknowledges, leaves alignment; stays in alignment if foreign_dual without align_valid
// - After exit, enter highest mode available
// - Unsaved coarse offset lost on reset
// - Bit 15 of command word is strobe
// - Act only on strobe rising edge
// - Strobe low clears acknowledge bit
// - Measurement needs valid config, setup, alignment; alignment checked only with foreign_dual, never on save exit
// - Report measurement and initialized bits at power-up
// - Entering measurement clears transducer faults
// - Bit 7 clears latched transducer faults
// - Bit 6 with preset stores offset in flash
// - Bit 5 presets channel 2, multi-turn errors
// - Bit 4 presets channel 1 or multi-turn
// - Bits 3,1 suppress channel LED status only
// - Bit 2 enables channel 2, multi-turn errors
// - Bit 0 enables channel 1 or multi-turn
// - All fields of a command apply together
// - Commands 0x8813 to 0x8873 error in multi-turn; range applies only to words with bits 1..0 = 3
// - Acknowledge plus result code in bits 3..0
package rmcd_pkg;

  typedef logic [15:0] rmcd_word_t;
  typedef logic [3:0] rmcd_result_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_MEAS = 3'b010,
    ST_ALIGN = 3'b100
  } rmcd_state_t;

  localparam int CMD_WORD_OFS = 0;

  localparam int BIT_STROBE = 15;
  localparam int BIT_CLR_FAULT = 7;
  localparam int BIT_FLASH = 6;
  localparam int BIT_PRESET2 = 5;
  localparam int BIT_PRESET1 = 4;
  localparam int BIT_LED_OFF2 = 3;
  localparam int BIT_EN2 = 2;
  localparam int BIT_LED_OFF1 = 1;
  localparam int BIT_EN1 = 0;

  localparam logic [7:0] MEAS_UPPER = 8'h88;
  localparam rmcd_word_t EXIT_CMD = 16'h800F;
  localparam rmcd_word_t SAVE_EXIT_CMD = 16'h800E;
  localparam rmcd_word_t MT_ERR_LO = 16'h8813;
  localparam rmcd_word_t MT_ERR_HI = 16'h8873;
  localparam logic [1:0] MT_ERR_LOW_BITS = 2'h3;

  localparam rmcd_result_t RES_OK = 4'h0;
  localparam rmcd_result_t RES_CMD_ERR = 4'h1;

  localparam logic RST_DATA_EN = 1'h0;
  localparam logic RST_LED_OFF = 1'h0;

  localparam int POS1_W = 32;
  localparam int VAL_W = 16;

endpackage

/* File: rtl/rmcd_gate.sv */
/*
  Registered zero gate for one position or velocity value.
  Assumes value and enable come from logic on the same clock.
*/
`timescale 1ns/100ps
module rmcd_gate #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic [WIDTH-1:0] value,
  output logic [WIDTH-1:0] gated_q
);

  // Disabled channels read as zero, not as stale data
  always_ff @(posedge clock) begin
    if (reset) begin
      gated_q <= '0;
    end else if (enable) begin
      gated_q <= value;
    end else begin
      gated_q <= '0;
    end
  end

endmodule

/* File: tb/rmcd_host.sv */
/*
  Host model: writes command word 0 of the cyclic output image.
  Assumes the bench calls its tasks and that it shares the decoder clock.
*/
`timescale 1ns/100ps
module rmcd_host
  import rmcd_pkg::*;
(
  input wire logic clock,
  output rmcd_pkg::rmcd_word_t cmd_word
);
  initial cmd_word = '0;

  task automatic drive(input rmcd_word_t w);
    @(posedge clock);
    cmd_word <= w;
  endtask

  // Zero word re-arms the strobe; hold keeps it high on purpose
  task automatic issue(input rmcd_word_t w, input logic hold);
    drive(w);
    drive(hold ? w : '0);
    #1;
  endtask
endmodule

/* File: tb/tb.sv */
/*
  Self-checking bench for the command decoder.
  Assumes the host model drives the command word; status inputs come from here.
*/
`timescale 1ns/100ps
module tb;
  import rmcd_pkg::*;
  logic clock, reset, config_valid, setup_valid, align_valid, foreign_dual;
  logic dual_multiturn, align_enter, led1_module_mode, led1_module_val, led1_chan_val;
  logic led2_module_mode, led2_module_val, led2_chan_val, ack_q, in_meas_q, initialized_q;
  logic in_align_q, fault_clear_q, preset1_q, preset2_q, preset_flash_q, coarse_discard_q;
  logic coarse_save_q, data_en1_q, data_en2_q, led_off1_q, led_off2_q, led1_q, led2_q;
  logic [POS1_W-1:0] pos1_value, pos1_q;
  logic [VAL_W-1:0] vel1_value, pos2_value, vel2_value, vel1_q, pos2_q, vel2_q;
  rmcd_word_t cmd_word;
  rmcd_result_t result_q;
  logic en1, en2, lo1, lo2, ok;
  int miscompares, check_count, cycles;
  rmcd_word_t words [8] = '{16'h8889, 16'h8840, 16'h8875, 16'h8819,
                            16'h8826, 16'h8865, 16'h8805, 16'h880A};
  rmcd_word_t dwords [6] = '{16'h8805, 16'h8826, 16'h8813, 16'h8873, 16'h8811, 16'h8851};
  rmcd_result_t dres [6] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0};

  rmcd_host i_host (.clock(clock), .cmd_word(cmd_word));
  rmcd_decoder i_dut (.clock(clock), .reset(reset), .cmd_word(cmd_word),
    .config_valid(config_valid), .setup_valid(setup_valid), .align_valid(align_valid),
    .foreign_dual(foreign_dual), .dual_multiturn(dual_multiturn), .align_enter(align_enter),
    .pos1_value(pos1_value), .vel1_value(vel1_value), .pos2_value(pos2_value),
    .vel2_value(vel2_value), .led1_module_mode(led1_module_mode),
    .led1_module_val(led1_module_val), .led1_chan_val(led1_chan_val),
    .led2_module_mode(led2_module_mode), .led2_module_val(led2_module_val),
    .led2_chan_val(led2_chan_val), .ack_q(ack_q), .result_q(result_q), .in_meas_q(in_meas_q),
    .initialized_q(initialized_q), .in_align_q(in_align_q), .fault_clear_q(fault_clear_q),
    .preset1_q(preset1_q), .preset2_q(preset2_q), .preset_flash_q(preset_flash_q),
    .coarse_discard_q(coarse_discard_q), .coarse_save_q(coarse_save_q),
    .data_en1_q(data_en1_q), .data_en2_q(data_en2_q), .led_off1_q(led_off1_q),
    .led_off2_q(led_off2_q), .led1_q(led1_q), .led2_q(led2_q), .pos1_q(pos1_q),
    .vel1_q(vel1_q), .pos2_q(pos2_q), .vel2_q(vel2_q));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Refused words must leave every field as it was
  task automatic meas(input rmcd_word_t w, input rmcd_result_t res);
    i_host.issue(w, 1'b0);
    ok = (res == RES_OK);
    if (ok) begin
      en1 = w[0];
      en2 = w[2];
      lo1 = w[1];
      lo2 = w[3];
    end
    check("ack", ack_q, 1'b1);
    check("result", result_q, res);
    check("fault_clear", fault_clear_q, ok & w[7]);
    check("flash", preset_flash_q, ok & w[6] & (w[5] | w[4]));
    check("preset2", preset2_q, ok & w[5]);
    check("preset1", preset1_q, ok & w[4]);
    check("led_off1", led_off1_q, lo1);
    check("led_off2", led_off2_q, lo2);
    check("data_en1", data_en1_q, en1);
    check("data_en2", data_en2_q, en2);
    @(posedge clock);
    #1;
    check("ack_low", ack_q, 1'b0);
    check("pulse_end", fault_clear_q, 1'b0);
    check("pos1", pos1_q, en1 ? pos1_value : '0);
    check("vel1", vel1_q, en1 ? vel1_value : '0);
    check("pos2", pos2_q, en2 ? pos2_value : '0);
    check("vel2", vel2_q, en2 ? vel2_value : '0);
  endtask

  task automatic pulse_align;
    @(posedge clock) align_enter <= 1'b1;
    @(posedge clock) align_enter <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("in_align", in_align_q, 1'b1);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    {reset, config_valid} = 2'b11;
    {setup_valid, align_valid, foreign_dual, dual_multiturn, align_enter} = '0;
    {led1_module_mode, led1_module_val, led1_chan_val} = '0;
    {led2_module_mode, led2_module_val, led2_chan_val} = '0;
    {en1, en2, lo1, lo2, ok} = '0;
    pos1_value = 32'h12345678;
    vel1_value = 16'hA5C3;
    pos2_value = 16'h3C5A;
    vel2_value = 16'h0F0F;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    meas(16'h8889, RES_CMD_ERR);
    @(posedge clock) setup_valid <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("in_meas", in_meas_q, 1'b1);
    check("initialized", initialized_q, 1'b1);
    // Words keep upper byte 0x88 and flash stores stay rare
    foreach (words[i]) meas(words[i], RES_OK);
    @(posedge clock) begin
      led1_chan_val <= 1'b1;
      led2_chan_val <= 1'b1;
      led2_module_mode <= 1'b1;
      led2_module_val <= 1'b1;
    end
    repeat (2) @(posedge clock);
    #1;
    check("led1", led1_q, 1'b0);
    check("led2", led2_q, 1'b1);
    // Module status must show through a suppressed channel indicator
    @(posedge clock) {led1_module_mode, led1_module_val} <= 2'b11;
    repeat (2) @(posedge clock);
    #1;
    check("led1_mod", led1_q, 1'b1);
    meas(16'h9001, RES_CMD_ERR);
    i_host.issue(16'h8881, 1'b1);
    repeat (2) @(posedge clock);
    #1;
    check("held_pulse", fault_clear_q, 1'b0);
    i_host.drive(16'h8885);
    repeat (3) @(posedge clock);
    #1;
    check("held_en2", data_en2_q, 1'b0);
    check("held_ack", ack_q, 1'b1);
    i_host.issue(16'h0000, 1'b0);
    @(posedge clock);
    #1;
    check("held_clr", ack_q, 1'b0);
    {en1, en2, lo1, lo2} = 4'b1000;
    @(posedge clock) dual_multiturn <= 1'b1;
    foreach (dwords[i]) meas(dwords[i], dres[i]);
    @(posedge clock) dual_multiturn <= 1'b0;
    @(posedge clock) foreign_dual <= 1'b1;
    pulse_align();
    meas(16'h8889, RES_CMD_ERR);
    i_host.issue(EXIT_CMD, 1'b0);
    check("exit_res", result_q, RES_OK);
    check("discard", coarse_discard_q, 1'b1);
    check("no_save", coarse_save_q, 1'b0);
    check("stay_align", in_align_q, 1'b1);
    @(posedge clock) align_valid <= 1'b1;
    i_host.issue(EXIT_CMD, 1'b0);
    check("exit_ack", ack_q, 1'b1);
    check("to_meas", in_meas_q, 1'b1);
    check("left_align", in_align_q, 1'b0);
    check("entry_clear", fault_clear_q, 1'b1);
    pulse_align();
    i_host.issue(SAVE_EXIT_CMD, 1'b0);
    check("save_ack", ack_q, 1'b1);
    check("save_res", result_q, RES_OK);
    check("save", coarse_save_q, 1'b1);
    check("save_keep", coarse_discard_q, 1'b0);
    check("save_meas", in_meas_q, 1'b1);
    check("save_left", in_align_q, 1'b0);
    check("save_clear", fault_clear_q, 1'b1);
    pulse_align();
    @(posedge clock) reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check("rst_align", in_align_q, 1'b0);
    check("rst_save", coarse_save_q, 1'b0);
    check("rst_meas", in_meas_q, 1'b1);
    conclude();
  end
endmodule
